// ===== src/bis_pkg.sv
package bis_pkg;
  // register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_MASK = 8'h04;
  localparam logic [7:0] REG_TRIG = 8'h08;
  localparam logic [7:0] REG_VBASE = 8'h0C;
  localparam logic [7:0] REG_ROUTE_LO = 8'h10;
  localparam logic [7:0] REG_ROUTE_HI = 8'h14;
  localparam logic [7:0] REG_STATUS = 8'h18;
  localparam logic [7:0] REG_POLL = 8'h1C;
  localparam logic [7:0] REG_EOI = 8'h20;
  localparam logic [7:0] REG_CNT_CTRL = 8'h24;
  localparam logic [7:0] REG_CNT [3] = '{8'h28, 8'h2C, 8'h30};
  // field positions
  localparam int CTRL_LOW_LSB = 8;
  localparam int EOI_SPEC_BIT = 3;
  localparam int CNT_AUTO_LSB = 3;
  localparam int POLL_FLAG_BIT = 7;
  // reset values
  localparam logic [7:0] MASK_RST = 8'hFF;
  localparam logic [7:0] TRIG_RST = 8'h00;
  localparam logic [4:0] VBASE_RST = 5'h04;
  localparam logic [31:0] ROUTE_RST = 32'h1F1F1F1F;
  localparam logic [2:0] LOW_RST = 3'h7;
  localparam logic [5:0] CNT_CTRL_RST = 6'h00;
  // sizes
  localparam int NUM_LEVELS = 8;
  localparam int NUM_SRC = 26;
  localparam int NUM_PINS = 24;
  localparam int NUM_CNT = 3;
  // fixed nonmaskable vector location
  localparam logic [19:0] NMI_VECTOR = 20'h00008;
  // counter tick divider
  localparam int CLK_HZ = 25000000;
  localparam int TICK_HZ = 1000000;
  localparam logic [4:0] TICK_DIV = 5'(CLK_HZ / TICK_HZ);
  // bus answers
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;
  typedef enum logic [1:0] {mode_nested, mode_rotate, mode_specific, mode_polled} bis_mode_t;
endpackage

// ===== src/bis_sync3.sv
`timescale 1ns/1ps
module bis_sync3 #(
  parameter int WIDTH = 1
) (
  input wire logic aclk, // clock
  input wire logic aresetn, // sync reset, low
  input wire logic [WIDTH-1:0] din, // asynchronous inputs
  output logic [WIDTH-1:0] dout // filtered levels
);
  logic [WIDTH-1:0] s1;
  logic [WIDTH-1:0] s2;
  logic [WIDTH-1:0] s3;

  // three-stage chain; s1 is read only by s2
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
    end
    else
    begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // a bit changes only once stages two and three agree
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      dout <= '0;
    else
      dout <= (s2 & s3) | (dout & (s2 | s3));
  end
endmodule

// ===== src/bis_top.sv
// Summary of operation
// RQ1 - Nine levels: nonmaskable line on top, then eight controller levels.
// RQ2 - Nonmaskable request cannot be masked; it vectors through location 00008H.
// RQ3 - Fully nested mode: line 0 highest, line 7 lowest.
// RQ4 - Rotating mode: a serviced level becomes lowest until the next one.
// RQ5 - Specific mode: software names the lowest level; others follow in order.
// RQ6 - Polled mode: software reads a priority-encoded status instead of vectors.
// RQ7 - Mode and priority may be changed at any time without reset.
// RQ8 - Interrupt only when the best pending request outranks the in-service level.
// RQ9 - One mask byte masks any combination of the eight levels.
// RQ10 - Each level has a 4-byte vector in a 32-byte table below 1K.
// RQ11 - After acknowledge the processor receives the identifier, then calls indirectly.
// RQ12 - Software should avoid the first 32 vector locations.
// RQ13 - Each controller input is routed from 26 possible sources.
// RQ14 - Parallel port raises input-full and output-empty requests.
// RQ15 - Each of three counters drives its own routable request.
// RQ16 - Eight backplane request lines are accepted.
// RQ17 - Expansion, conversion, power-fail, line clock, fail-safe, driver line are sources.
// RQ18 - Power-fail is accepted only together with the AC-low indication.
// RQ19 - Three independent 16-bit counters; the third also times memory writes.
// RQ20 - An 8-bit identifier is supplied; vector address is identifier times four.
// RQ21 - Each input responds to edges or levels as programmed.
// RQ22 - Masked levels ignored; unmasked requests stay pending until acknowledged. Here only edge inputs do; level inputs follow the line.
`timescale 1ns/1ps
module bis_top (
  input wire logic aclk, // clock, 25 MHz
  input wire logic aresetn, // sync reset, low
  input wire logic [7:0] awaddr, // write address
  input wire logic awvalid, // write address valid
  output logic awready, // write address ready
  input wire logic [31:0] wdata, // write data
  input wire logic [3:0] wstrb, // write byte enables
  input wire logic wvalid, // write data valid
  output logic wready, // write data ready
  output logic [1:0] bresp, // write response
  output logic bvalid, // write response valid
  input wire logic bready, // write response ready
  input wire logic [7:0] araddr, // read address
  input wire logic arvalid, // read address valid
  output logic arready, // read address ready
  output logic [31:0] rdata, // read data
  output logic [1:0] rresp, // read response
  output logic rvalid, // read data valid
  input wire logic rready, // read data ready
  output logic intr, // interrupt to processor
  input wire logic inta, // acknowledge pulse from processor
  output logic [7:0] vec_id, // identifier byte
  output logic [9:0] vec_addr, // identifier times four
  output logic id_valid, // identifier strobe
  output logic nmi, // nonmaskable request
  output logic [19:0] nmi_vector, // fixed nonmaskable vector
  output logic nvm_wr_busy, // third counter timing a memory write
  input wire logic ppi_in_full, // parallel input buffer full
  input wire logic ppi_out_empty, // parallel output buffer empty
  input wire logic [7:0] bus_req, // backplane requests
  input wire logic [5:0] exp_req, // expansion connector requests
  input wire logic eoc, // end of conversion
  input wire logic power_fail_request_in, // power-fail request
  input wire logic ac_low, // AC-low from supply
  input wire logic line_clk, // line-frequency clock
  input wire logic failsafe, // fail-safe timer
  input wire logic drv_req, // parallel driver section line
  input wire logic [1:0] aux_req // spare sources
);
  import bis_pkg::*;

  logic aw_have;
  logic w_have;
  logic wr_fire;
  logic rd_fire;
  logic [7:0] aw_q;
  logic [31:0] w_q;
  logic [3:0] s_q;
  logic [31:0] wv;
  bis_mode_t mode;
  logic [2:0] lowest;
  logic [7:0] mask;
  logic [7:0] trig;
  logic [4:0] vbase;
  logic [31:0] route_lo;
  logic [31:0] route_hi;
  logic [5:0] cnt_ctrl;
  logic [15:0] cnt_val [NUM_CNT];
  logic [15:0] cnt_rld [NUM_CNT];
  logic [2:0] cnt_run;
  logic [2:0] cnt_term;
  logic [4:0] tick_cnt;
  logic tick;
  logic [NUM_PINS-1:0] pins;
  logic [1:0] s_aux;
  logic s_drv, s_fs, s_line, s_acl, s_pf, s_eoc, s_pout, s_pin;
  logic [5:0] s_exp;
  logic [7:0] s_bus;
  logic pf_ok;
  logic [NUM_SRC-1:0] src;
  logic [7:0] routed;
  logic [7:0] routed_d;
  logic [7:0] irr;
  logic [7:0] isr;
  logic [2:0] eff_low;
  logic [3:0] req_pick;
  logic [3:0] isr_pick;
  logic outranks;
  logic take;
  logic poll_ack;
  logic eoi_wr;
  logic eoi_hit;
  logic [2:0] eoi_lvl;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // rank 0 is the highest priority for a given lowest level
  function automatic logic [2:0] bis_rank(input logic [2:0] lvl, input logic [2:0] low);
    return 3'(lvl - low - 3'h1);
  endfunction

  // best set bit of v, scanning from just above the lowest level
  function automatic logic [3:0] bis_pick(input logic [7:0] v, input logic [2:0] low);
    logic [3:0] r;
    logic [2:0] l;
    r = 4'h0;
    for (int k = NUM_LEVELS - 1; k >= 0; k--)
    begin
      l = 3'(low + 3'h1 + 3'(k));
      if (v[l])
        r = {1'b1, l};
    end
    return r;
  endfunction

  // byte-lane merge of a write into the old value
  function automatic logic [31:0] bis_merge(input logic [31:0] old, input logic [31:0] nw,
                                            input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
    begin
      if (strb[b])
        r[8*b+:8] = nw[8*b+:8];
    end
    return r;
  endfunction

  // read value of a register
  function automatic logic [31:0] bis_read(input logic [7:0] a);
    logic [31:0] v;
    v = 32'h0;
    case (a)
      REG_CTRL: v = {21'h0, lowest, 6'h0, 2'(mode)};
      REG_MASK: v = {24'h0, mask};
      REG_TRIG: v = {24'h0, trig};
      REG_VBASE: v = {27'h0, vbase};
      REG_ROUTE_LO: v = route_lo;
      REG_ROUTE_HI: v = route_hi;
      REG_STATUS: v = {15'h0, nmi, isr, irr};
      REG_POLL: v = {24'h0, req_pick[3] & outranks, 4'h0, req_pick[2:0]}; // RQ6
      REG_CNT_CTRL: v = {26'h0, cnt_ctrl};
      REG_CNT[0]: v = {16'h0, cnt_val[0]};
      REG_CNT[1]: v = {16'h0, cnt_val[1]};
      REG_CNT[2]: v = {16'h0, cnt_val[2]};
      default: v = 32'h0;
    endcase
    return v;
  endfunction

  // mapped address check; status and poll are read-only
  function automatic logic bis_ok(input logic [7:0] a, input logic wr);
    logic r;
    case (a)
      REG_CTRL, REG_MASK, REG_TRIG, REG_VBASE, REG_ROUTE_LO, REG_ROUTE_HI,
      REG_CNT_CTRL, REG_CNT[0], REG_CNT[1], REG_CNT[2]: r = 1'b1;
      REG_STATUS, REG_POLL: r = !wr;
      REG_EOI: r = wr;
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // register bus slave

  assign awready = !aw_have;
  assign wready = !w_have;
  assign arready = !rvalid;
  assign wr_fire = aw_have && w_have && !bvalid;
  assign rd_fire = arvalid && arready;
  assign wv = bis_merge(bis_read(aw_q), w_q, s_q);

  // address and data are taken in either order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have <= 1'b0;
      w_have <= 1'b0;
      aw_q <= 8'h00;
      w_q <= 32'h0;
      s_q <= 4'h0;
    end
    else
    begin
      if (awvalid && awready)
      begin
        aw_have <= 1'b1;
        aw_q <= awaddr;
      end
      else if (wr_fire)
        aw_have <= 1'b0;
      if (wvalid && wready)
      begin
        w_have <= 1'b1;
        w_q <= wdata;
        s_q <= wstrb;
      end
      else if (wr_fire)
        w_have <= 1'b0;
    end
  end

  // write response
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid <= 1'b0;
      bresp <= AXI_OKAY;
    end
    else if (wr_fire)
    begin
      bvalid <= 1'b1;
      bresp <= bis_ok(aw_q, 1'b1) ? AXI_OKAY : AXI_SLVERR;
    end
    else if (bready)
      bvalid <= 1'b0;
  end

  // read data captured on the address handshake
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= AXI_OKAY;
    end
    else if (rd_fire)
    begin
      rvalid <= 1'b1;
      rdata <= bis_read(araddr);
      rresp <= bis_ok(araddr, 1'b0) ? AXI_OKAY : AXI_SLVERR;
    end
    else if (rready)
      rvalid <= 1'b0;
  end

  // configuration registers, effective on the next cycle
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      mode <= mode_nested;
      mask <= MASK_RST;
      trig <= TRIG_RST;
      vbase <= VBASE_RST;
      route_lo <= ROUTE_RST;
      route_hi <= ROUTE_RST;
      cnt_ctrl <= CNT_CTRL_RST;
    end
    else if (wr_fire)
    begin
      case (aw_q)
        REG_CTRL: mode <= bis_mode_t'(wv[1:0]); // RQ7
        REG_MASK: mask <= wv[7:0]; // RQ9
        REG_TRIG: trig <= wv[7:0]; // RQ21
        REG_VBASE: vbase <= wv[4:0]; // RQ10
        REG_ROUTE_LO: route_lo <= wv; // RQ13
        REG_ROUTE_HI: route_hi <= wv;
        REG_CNT_CTRL: cnt_ctrl <= wv[5:0];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // request sources and routing

  bis_sync3 #(
    .WIDTH(NUM_PINS)
  ) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .din({aux_req, drv_req, failsafe, line_clk, ac_low, power_fail_request_in, eoc,
          exp_req, bus_req, ppi_out_empty, ppi_in_full}),
    .dout(pins)
  );

  assign {s_aux, s_drv, s_fs, s_line, s_acl, s_pf, s_eoc, s_exp, s_bus, s_pout, s_pin} = pins;
  assign pf_ok = s_pf & s_acl; // RQ18

  // source vector, 26 entries
  assign src = {s_aux, s_drv, s_fs, s_line, pf_ok, s_eoc, s_exp, // RQ17
                s_bus, // RQ16
                cnt_term, // RQ15
                s_pout, s_pin}; // RQ14

  // each level selects one source; codes past the last source select none
  always_comb
  begin
    logic [4:0] sel;
    sel = 5'h00;
    for (int i = 0; i < NUM_LEVELS; i++)
    begin
      sel = (i < 4) ? route_lo[8*i+:5] : route_hi[8*(i-4)+:5];
      routed[i] = (sel < 5'(NUM_SRC)) ? src[sel] : 1'b0; // RQ13
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // priority resolution

  assign eff_low = (mode == mode_rotate || mode == mode_specific) ? lowest : 3'h7; // RQ3 RQ5
  assign req_pick = bis_pick(irr & ~mask, eff_low); // RQ9 RQ22
  assign isr_pick = bis_pick(isr, eff_low);
  assign outranks = !isr_pick[3] ||
                    (bis_rank(req_pick[2:0], eff_low) < bis_rank(isr_pick[2:0], eff_low));
  assign intr = req_pick[3] && outranks && (mode != mode_polled); // RQ8 RQ6
  assign poll_ack = rd_fire && (araddr == REG_POLL) && req_pick[3] && outranks; // RQ6
  assign take = (inta || poll_ack) && req_pick[3];
  assign eoi_wr = wr_fire && (aw_q == REG_EOI);
  assign eoi_lvl = wv[EOI_SPEC_BIT] ? wv[2:0] : isr_pick[2:0];
  assign eoi_hit = eoi_wr && (wv[EOI_SPEC_BIT] || isr_pick[3]);

  // pending requests: edge inputs are sticky until taken, level inputs follow the line
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      routed_d <= 8'h00;
      irr <= 8'h00;
    end
    else
    begin
      routed_d <= routed;
      for (int i = 0; i < NUM_LEVELS; i++)
      begin
        if (trig[i])
          irr[i] <= (irr[i] & !(take && req_pick[2:0] == 3'(i))) | // RQ22
                    (routed[i] & !routed_d[i]); // RQ21
        else
          irr[i] <= routed[i]; // RQ21
      end
    end
  end

  // in-service bits; a new take wins over an end-of-service in the same cycle
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      isr <= 8'h00;
    else
    begin
      for (int i = 0; i < NUM_LEVELS; i++)
        isr[i] <= (isr[i] & !(eoi_hit && eoi_lvl == 3'(i))) |
                  (take && req_pick[2:0] == 3'(i)); // RQ8
    end
  end

  // lowest level: set by software, or moved to the serviced level in rotation
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      lowest <= LOW_RST;
    else if (wr_fire && aw_q == REG_CTRL)
      lowest <= wv[CTRL_LOW_LSB+:3]; // RQ5 RQ7
    else if (eoi_hit && mode == mode_rotate)
      lowest <= eoi_lvl; // RQ4
  end

  // identifier and vector address handed to the processor on acknowledge
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      vec_id <= 8'h00;
      vec_addr <= 10'h000;
      id_valid <= 1'b0;
    end
    else
    begin
      id_valid <= inta; // RQ11
      if (inta)
      begin
        vec_id <= {vbase, req_pick[3] ? req_pick[2:0] : 3'h7}; // RQ20
        vec_addr <= {vbase, req_pick[3] ? req_pick[2:0] : 3'h7, 2'h0}; // RQ10 RQ20
      end
    end
  end

  // nonmaskable line, outside the mask and priority logic
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      nmi <= 1'b0;
    else
      nmi <= pf_ok; // RQ1 RQ2 RQ18
  end

  assign nmi_vector = NMI_VECTOR; // RQ2

  ////////////////////////////////////////////////////////////////////////////
  // interval counters

  // one-cycle tick at the counter rate
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      tick_cnt <= 5'h00;
    else if (tick)
      tick_cnt <= 5'h00;
    else
      tick_cnt <= tick_cnt + 5'h01;
  end

  assign tick = (tick_cnt == TICK_DIV - 5'h01);

  // load on write, count down per tick, flag one tick at terminal count
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      for (int i = 0; i < NUM_CNT; i++)
      begin
        cnt_val[i] <= 16'h0000;
        cnt_rld[i] <= 16'h0000;
      end
      cnt_run <= 3'h0;
      cnt_term <= 3'h0;
    end
    else
    begin
      for (int i = 0; i < NUM_CNT; i++)
      begin
        if (wr_fire && aw_q == REG_CNT[i])
        begin
          cnt_rld[i] <= wv[15:0];
          cnt_val[i] <= wv[15:0];
          cnt_run[i] <= 1'b1;
        end
        else if (tick && cnt_run[i] && cnt_ctrl[i])
        begin
          if (cnt_val[i] == 16'h0001)
          begin
            cnt_val[i] <= cnt_rld[i];
            cnt_run[i] <= cnt_ctrl[CNT_AUTO_LSB+i]; // RQ19
          end
          else
            cnt_val[i] <= cnt_val[i] - 16'h0001; // RQ19
        end
        if (tick)
          cnt_term[i] <= cnt_run[i] && cnt_ctrl[i] && cnt_val[i] == 16'h0001; // RQ15
      end
    end
  end

  // third counter doubles as the memory write timer
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      nvm_wr_busy <= 1'b0;
    else
      nvm_wr_busy <= cnt_run[2]; // RQ19
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_nmi_gate: assert property (pf_ok |=> nmi ##1 (nmi || !$past(pf_ok))) // RQ18
    else $error("nmi did not follow gated power-fail");
  chk_nmi_free: assert property (!pf_ok |=> !nmi) // RQ2
    else $error("nmi raised without gated power-fail");
  chk_polled_quiet: assert property (mode == mode_polled |-> !intr) // RQ6
    else $error("interrupt raised in polled mode");
  chk_mask_block: assert property (intr |-> |(irr & ~mask)) // RQ9
    else $error("interrupt with only masked requests");
  chk_take_service: assert property (inta && intr |=> isr[vec_id[2:0]] && id_valid) // RQ8
    else $error("acknowledged level not in service");
  chk_nested_top: assert property (mode == mode_nested && irr[0] && !mask[0] && inta
                                   |=> vec_id[2:0] == 3'h0) // RQ3
    else $error("line 0 lost in nested mode");
  chk_rotate_low: assert property (eoi_hit && mode == mode_rotate &&
                                   !(wr_fire && aw_q == REG_CTRL) |=> lowest == $past(eoi_lvl)) // RQ4
    else $error("rotation did not lower serviced level");
  chk_id_table: assert property (id_valid |-> vec_addr == {vec_id[7:0], 2'h0}) // RQ10
    else $error("vector address not identifier times four");
  chk_edge_hold: assert property (trig[1] && irr[1] && !(take && req_pick[2:0] == 3'h1)
                                  |=> irr[1]) // RQ22
    else $error("edge request dropped before acknowledge");
  chk_bresp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped early");

  cov_vector: cover property (intr ##1 inta ##1 id_valid);
  cov_poll: cover property (poll_ack);
  cov_rotate: cover property (mode == mode_rotate && eoi_hit);
  cov_nmi: cover property ($rose(nmi));
endmodule

// ===== verif/bis_cpu_model.sv
`timescale 1ns/1ps
module bis_cpu_model (
  input wire logic aclk, // clock
  input wire logic aresetn, // sync reset, low
  input wire logic intr, // request level from the controller
  input wire logic [2:0] dly, // extra idle cycles after an acknowledge
  output logic inta // one-cycle acknowledge
);
  int hold;
  // acknowledge a raised request, then idle while the identifier lands
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      inta <= 1'b0;
      hold <= 0;
    end
    else if (hold != 0)
    begin
      inta <= 1'b0;
      hold <= hold - 1;
    end
    else
    begin
      inta <= intr;
      hold <= intr ? 3 + int'(dly) : 0;
    end
  end
endmodule

// ===== verif/bis_top_tb.sv
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin fail_count++; $display("[FAIL] %0t got %h exp %h", $time, (g), (e)); end end
module bis_top_tb;
  import bis_pkg::*;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, inta;
  logic awready, wready, bvalid, arready, rvalid, intr, id_valid, nmi, pf, ac_low, nvm_busy;
  logic [33:0] exp_r;
  logic [1:0] exp_b;
  logic [7:0] exp_v;
  logic [7:0] awaddr, araddr, bus_req, vec_id;
  logic [31:0] wdata, rdata, rnd;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, aux_req;
  logic [9:0] vec_addr;
  logic [19:0] nmi_vector;
  logic [11:0] noise;
  logic [2:0] dly;
  logic [4:0] vbase;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  logic [7:0] vq[$];
  int fail_count, check_count, seed;
  ////////////////////
  bis_top u_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .intr(intr), .inta(inta), .vec_id(vec_id), .vec_addr(vec_addr), .id_valid(id_valid),
    .nmi(nmi), .nmi_vector(nmi_vector), .nvm_wr_busy(nvm_busy), .ppi_in_full(noise[0]),
    .ppi_out_empty(noise[1]), .bus_req(bus_req), .exp_req(noise[7:2]), .eoc(noise[8]),
    .power_fail_request_in(pf), .ac_low(ac_low), .line_clk(noise[9]), .failsafe(noise[10]),
    .drv_req(noise[11]), .aux_req(aux_req));
  bis_cpu_model u_cpu (.aclk(aclk), .aresetn(aresetn), .intr(intr), .dly(dly), .inta(inta));
  ////////////////////
  // clock
  initial
  begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  // unrouted sources toggle at random; the processor pace varies
  always @(posedge aclk)
  begin
    noise <= 12'($random(seed));
    dly <= 3'($random(seed));
  end
  // result watcher: oldest note against each result
  always @(negedge aclk)
  begin
    if (rvalid && rready)
    begin
      exp_r = rq.pop_front();
      `CHK({rresp, rdata}, exp_r)
    end
    if (bvalid && bready)
    begin
      exp_b = bq.pop_front();
      `CHK(bresp, exp_b)
    end
    if (id_valid)
    begin
      exp_v = vq.pop_front();
      `CHK({vec_addr, vec_id}, {exp_v, 2'b00, exp_v})
    end
  end
  ////////////////////
  task automatic wrap_up();
    $display("checks %0d failures %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic late(input int n);
    if (n >= 300)
    begin
      fail_count++;
      $display("[FAIL] %0t no answer", $time);
    end
  endtask
  // bus write: hold each channel until its own handshake
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    logic ad, wd, bd;
    int n;
    bd = 1'b0;
    n = 0;
    bq.push_back(r);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    {awvalid, wvalid, bready} <= 3'b111;
    while (!bd && n < 300)
    begin
      @(negedge aclk);
      {ad, wd, bd} = {awvalid & awready, wvalid & wready, bvalid & bready};
      @(posedge aclk);
      if (ad) awvalid <= 1'b0;
      if (wd) wvalid <= 1'b0;
      n++;
    end
    bready <= 1'b0;
    late(n);
    @(posedge aclk);
  endtask
  // bus read
  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    logic ad, rdn;
    int n;
    rdn = 1'b0;
    n = 0;
    rq.push_back(e);
    araddr <= a;
    {arvalid, rready} <= 2'b11;
    while (!rdn && n < 300)
    begin
      @(negedge aclk);
      {ad, rdn} = {arvalid & arready, rvalid & rready};
      @(posedge aclk);
      if (ad) arvalid <= 1'b0;
      n++;
    end
    rready <= 1'b0;
    late(n);
    @(posedge aclk);
  endtask
  task automatic settle(input logic [7:0] req);
    bus_req <= req;
    repeat (8) @(posedge aclk);
  endtask
  task automatic qwait();
    int n;
    n = 0;
    while (vq.size() != 0 && n < 300)
    begin
      @(posedge aclk);
      n++;
    end
    late(n);
    repeat (4) @(posedge aclk);
  endtask
  task automatic expv(input logic [2:0] lv);
    vq.push_back({vbase, lv});
  endtask
  task automatic eoi();
    wr(REG_EOI, 32'h0, AXI_OKAY);
  endtask
  ////////////////////
  // watchdog
  initial
  begin
    #(40 * 30000);
    fail_count++;
    $display("[FAIL] %0t watchdog", $time);
    wrap_up();
  end
  // main sequence
  initial
  begin
    seed = 65;
    {aresetn, awvalid, wvalid, bready, arvalid, rready, pf, ac_low} = 8'h00;
    {awaddr, araddr, bus_req, wdata, wstrb, aux_req} = '0;
    {noise, dly} = '0;
    vbase = 5'h05;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(REG_CTRL, {AXI_OKAY, 21'h0, LOW_RST, 8'h00});
    rd(REG_MASK, {AXI_OKAY, 24'h0, MASK_RST});
    rd(REG_VBASE, {AXI_OKAY, 27'h0, VBASE_RST});
    rd(REG_ROUTE_HI, {AXI_OKAY, ROUTE_RST});
    rd(8'h40, {AXI_SLVERR, 32'h0});
    rd(REG_EOI, {AXI_SLVERR, 32'h0});
    wr(REG_STATUS, 32'hFFFFFFFF, AXI_SLVERR);
    wr(REG_ROUTE_LO, 32'h08070605, AXI_OKAY);
    wr(REG_ROUTE_HI, 32'h190B0A09, AXI_OKAY);
    wr(REG_VBASE, 32'h5, AXI_OKAY);
    wr(REG_MASK, 32'h0, AXI_OKAY);
    // nested: 3 beats 5, 5 waits for the end of service
    expv(3);
    settle(8'h28);
    qwait();
    expv(5);
    settle(8'h20);
    eoi();
    qwait();
    // masked level skipped, lower one served
    wr(REG_MASK, 32'h20, AXI_OKAY);
    expv(6);
    settle(8'h60);
    eoi();
    qwait();
    settle(8'h00);
    eoi();
    wr(REG_MASK, 32'h0, AXI_OKAY);
    // rotating: after 2 is served, 3 outranks 1
    wr(REG_CTRL, 32'h00000701, AXI_OKAY);
    expv(2);
    settle(8'h04);
    qwait();
    settle(8'h00);
    eoi();
    expv(3);
    settle(8'h0A);
    qwait();
    expv(1);
    settle(8'h02);
    eoi();
    qwait();
    settle(8'h00);
    eoi();
    // specific: lowest 5 makes 6 the best
    wr(REG_CTRL, 32'h00000502, AXI_OKAY);
    expv(6);
    settle(8'h50);
    qwait();
    settle(8'h00);
    eoi();
    // polled: status by read, no interrupt
    wr(REG_CTRL, 32'h00000703, AXI_OKAY);
    settle(8'h10);
    @(negedge aclk);
    `CHK(intr, 1'b0)
    @(posedge aclk);
    rd(REG_POLL, {AXI_OKAY, 24'h0, 8'h84});
    rd(REG_STATUS, {AXI_OKAY, 32'h00001010});
    settle(8'h00);
    eoi();
    // edge trigger keeps a short pulse pending
    wr(REG_CTRL, 32'h00000700, AXI_OKAY);
    wr(REG_TRIG, 32'h1, AXI_OKAY);
    expv(0);
    settle(8'h01);
    settle(8'h00);
    qwait();
    eoi();
    rnd = $random(seed);
    wr(REG_TRIG, rnd, AXI_OKAY);
    rd(REG_TRIG, {AXI_OKAY, 24'h0, rnd[7:0]});
    wr(REG_TRIG, 32'h0, AXI_OKAY);
    // last source code reaches level 7
    expv(7);
    aux_req <= 2'b10;
    qwait();
    aux_req <= 2'b00;
    repeat (8) @(posedge aclk);
    eoi();
    // third counter: one-shot of three ticks, its terminal count raises level 0
    wr(REG_ROUTE_LO, 32'h08070604, AXI_OKAY);
    wr(REG_CNT_CTRL, 32'h4, AXI_OKAY);
    expv(0);
    wr(REG_CNT[2], 32'h3, AXI_OKAY);
    @(negedge aclk);
    `CHK(nvm_busy, 1'b1)
    repeat (100) @(posedge aclk);
    @(negedge aclk);
    `CHK(nvm_busy, 1'b0)
    @(posedge aclk);
    rd(REG_CNT[2], {AXI_OKAY, 32'h3});
    eoi();
    // nonmaskable line needs the supply's low indication
    wr(REG_MASK, 32'hFF, AXI_OKAY);
    pf <= 1'b1;
    repeat (10) @(posedge aclk);
    @(negedge aclk);
    `CHK(nmi, 1'b0)
    @(posedge aclk);
    ac_low <= 1'b1;
    repeat (10) @(posedge aclk);
    @(negedge aclk);
    `CHK(nmi, 1'b1)
    `CHK(nmi_vector, NMI_VECTOR)
    `CHK(intr, 1'b0)
    wrap_up();
  end
endmodule
